// File: hw/sarr_map.svh
// constants of the sar serial readout block
`ifndef SARR_MAP_SVH
`define SARR_MAP_SVH
// ************************************************************
// clock and timing
// ************************************************************
`define SARR_CLK_MHZ 100
`define SARR_POWERUP_NS 1000
`define SARR_RELEASE_NS 40
// ************************************************************
// frame layout
// ************************************************************
`define SARR_WORD_BITS 16
`define SARR_LEAD_ZEROS 4
`define SARR_RESULT_BITS 12
`define SARR_LAST_FALL 5'h10
`define SARR_LAST_DECISION 4'hc
`define SARR_TRIAL_FIRST 12'h800
`define SARR_FIFO_DEPTH 32
`endif

// File: hw/sarr_pkg.sv
// shared types of the sar serial readout block
`include "sarr_map.svh"
package sarr_pkg;
  // host pins after synchronisation
  typedef struct packed {
    logic frame_sel_n;
    logic serial_clk;
  } sarr_pins_s;
  // one finished conversion
  typedef struct packed {
    logic [`SARR_RESULT_BITS-1:0] code;
  } sarr_result_s;
  // frame sequencing states
  typedef enum logic [1:0] {
    st_down,
    st_track,
    st_convert,
    st_release
  } sarr_state_e;
endpackage

// File: hw/sarr_readout.sv
// sar adc conversion sequencer, serial readout and result fifo

`timescale 1ns/10ps
`default_nettype none
`include "sarr_map.svh"

// ************************************************************
// result fifo
// ************************************************************
// depth must be a power of two: the wrap bit above each
// pointer tells full from empty without a separate counter
module sarr_fifo #(
  parameter int WIDTH = `SARR_RESULT_BITS,
  parameter int DEPTH = `SARR_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // storage and pointers, one wrap bit above the index
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  // handshake decode
  wire do_push;
  wire do_pop;
  wire ptr_msb_differ;

  // full when pointers meet with wrap bits apart
  assign ptr_msb_differ = wr_ptr[AW] != rd_ptr[AW];
  assign in_ready = !(ptr_msb_differ && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = wr_ptr != rd_ptr;
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr[AW-1:0]];

  // storage has no reset, pointers define content
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // pointer update
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // sarr_fifo

// ************************************************************
// top: sequencer, sar and serial shifter
// ************************************************************
module sarr_readout #(
  parameter int FIFO_DEPTH = `SARR_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // host pins
  input wire logic frame_sel_n,
  input wire logic serial_clk,
  output logic serial_result_out,
  output logic serial_result_oe,
  // analog front end control
  output logic analog_powered,
  output logic track_mode,
  output logic powerup_done,
  output logic [`SARR_RESULT_BITS-1:0] sar_trial,
  input wire logic comp_high,
  // result stream to local logic
  output logic result_valid,
  input wire logic result_ready,
  output sarr_pkg::sarr_result_s result_data,
  output logic result_room
);
  // cycle counts from the core clock rate; power-up rounds up,
  // release rounds down but never below one cycle
  localparam int POWERUP_CYC = (`SARR_POWERUP_NS * `SARR_CLK_MHZ + 999) / 1000;
  localparam int RELEASE_RAW = (`SARR_RELEASE_NS * `SARR_CLK_MHZ) / 1000;
  localparam int RELEASE_CYC = (RELEASE_RAW < 1) ? 1 : RELEASE_RAW;
  localparam int TW = $clog2(POWERUP_CYC + 1);

  // pin samples: metastable, settled, one cycle older
  sarr_pkg::sarr_pins_s pins_meta;
  sarr_pkg::sarr_pins_s pins_sync;
  sarr_pkg::sarr_pins_s pins_last;
  logic comp_meta;
  logic comp_sync;
  // sequencing, timing and conversion state
  sarr_pkg::sarr_state_e state;
  sarr_pkg::sarr_state_e next_state;
  logic [TW-1:0] timer;
  logic [4:0] fall_cnt;
  logic [3:0] rise_cnt;
  logic [`SARR_RESULT_BITS-1:0] sar_mask;
  // one-cycle push strobe into the fifo
  logic push_pulse;

  // ************************************************************
  // pin synchronisers and edge detect
  // ************************************************************
  // two flops before any logic sees a pin
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pins_meta <= '1;
      pins_sync <= '1;
      pins_last <= '1;
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      pins_meta <= {frame_sel_n, serial_clk};
      pins_sync <= pins_meta;
      pins_last <= pins_sync;
      // comparator crosses in from the analog side as well
      comp_meta <= comp_high;
      comp_sync <= comp_meta;
    end
  end

  // edges one flop after the synchroniser; a pin must hold each
  // level for a few core cycles or an edge is lost
  wire sel_fall = pins_last.frame_sel_n && !pins_sync.frame_sel_n;
  wire sel_rise = !pins_last.frame_sel_n && pins_sync.frame_sel_n;
  wire sclk_fall = pins_last.serial_clk && !pins_sync.serial_clk;
  wire sclk_rise = !pins_last.serial_clk && pins_sync.serial_clk;

  // ************************************************************
  // sequencing decode
  // ************************************************************
  // the comparator is trusted for twelve rises only; later
  // rises of the sixteen-clock frame are idle
  wire in_convert = state == sarr_pkg::st_convert;
  wire step_fall = in_convert && sclk_fall;
  wire step_rise = in_convert && sclk_rise && (rise_cnt != `SARR_LAST_DECISION);
  wire [4:0] fall_next = fall_cnt + 5'h01;
  wire frame_done = step_fall && (fall_next == `SARR_LAST_FALL);
  wire release_done = (state == sarr_pkg::st_release) && (timer == TW'(RELEASE_CYC - 1));
  // word layout and the bit that the next fall presents
  wire [`SARR_WORD_BITS-1:0] out_word = {`SARR_LEAD_ZEROS'h0, sar_trial};
  wire [3:0] next_bit_index = 4'(`SARR_WORD_BITS - 1) - fall_next[3:0];
  wire [`SARR_RESULT_BITS-1:0] kept_code = comp_sync ? sar_trial : (sar_trial & ~sar_mask);

  // state transitions; a select fall always restarts tracking
  always_comb begin
    next_state = state;
    case (state)
      sarr_pkg::st_down: begin
        if (sel_fall) next_state = sarr_pkg::st_track;
      end
      sarr_pkg::st_track: begin
        if (sel_rise) next_state = sarr_pkg::st_convert;
      end
      sarr_pkg::st_convert: begin
        if (sel_fall) next_state = sarr_pkg::st_track;
        else if (frame_done) next_state = sarr_pkg::st_release;
      end
      sarr_pkg::st_release: begin
        if (sel_fall) next_state = sarr_pkg::st_track;
        else if (release_done) next_state = sarr_pkg::st_down;
      end
      // an unused code recovers to power-down
      default: next_state = sarr_pkg::st_down;
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) state <= sarr_pkg::st_down;
    else state <= next_state;
  end

  // ************************************************************
  // power-up and release timer
  // ************************************************************
  // shared counter: power-up in track, output hold in release
  // a select rise before power-up ends still converts; the flag
  // lets local logic tell such a sample from a settled one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      timer <= '0;
      powerup_done <= 1'b0;
    end else if (next_state != state) begin
      timer <= '0;
      if (next_state == sarr_pkg::st_track) powerup_done <= 1'b0;
    end else if (state == sarr_pkg::st_track && !powerup_done) begin
      timer <= timer + 1'b1;
      if (timer == TW'(POWERUP_CYC - 1)) powerup_done <= 1'b1;
    end else if (state == sarr_pkg::st_release) begin
      timer <= timer + 1'b1;
    end
  end

  // ************************************************************
  // successive approximation
  // ************************************************************
  // one decision per rising edge, msb first, twelve in all
  // a bit keeps its trial value only if the input reached it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sar_trial <= `SARR_TRIAL_FIRST;
      sar_mask <= `SARR_TRIAL_FIRST;
      rise_cnt <= '0;
    end else if (sel_rise && state == sarr_pkg::st_track) begin
      // every frame starts again from mid-scale
      sar_trial <= `SARR_TRIAL_FIRST;
      sar_mask <= `SARR_TRIAL_FIRST;
      rise_cnt <= '0;
    end else if (step_rise) begin
      sar_trial <= kept_code | (sar_mask >> 1);
      sar_mask <= sar_mask >> 1;
      rise_cnt <= rise_cnt + 4'h1;
    end
  end

  // ************************************************************
  // serial shifter and output driver
  // ************************************************************
  // data changes only on falls; driven only inside the frame
  // the sixteenth fall keeps the lsb on the pin until release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      serial_result_out <= 1'b0;
      serial_result_oe <= 1'b0;
      fall_cnt <= '0;
    end else if (next_state == sarr_pkg::st_convert && state == sarr_pkg::st_track) begin
      // leading zero straight from the select rise
      serial_result_out <= 1'b0;
      serial_result_oe <= 1'b1;
      fall_cnt <= '0;
    end else if (next_state == sarr_pkg::st_down || next_state == sarr_pkg::st_track) begin
      // abort or end of release hold: line released at once
      serial_result_out <= 1'b0;
      serial_result_oe <= 1'b0;
      fall_cnt <= '0;
    end else if (step_fall) begin
      fall_cnt <= fall_next;
      if (!frame_done) serial_result_out <= out_word[next_bit_index];
    end
  end

  // ************************************************************
  // analog control and result hand-off
  // ************************************************************
  // power and track follow the state directly, so they move
  // in the same cycle as the sequencer
  assign analog_powered = state != sarr_pkg::st_down;
  assign track_mode = state == sarr_pkg::st_track;

  // one push per completed frame; a full fifo drops the word,
  // because the host clock cannot be stalled
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) push_pulse <= 1'b0;
    else push_pulse <= frame_done;
  end

  // results wait here until local logic takes them
  sarr_fifo #(
    .WIDTH(`SARR_RESULT_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(push_pulse),
    .in_ready(result_room),
    .in_data(sar_trial),
    .out_valid(result_valid),
    .out_ready(result_ready),
    .out_data(result_data.code)
  );
endmodule // sarr_readout

`default_nettype wire

// File: sim/sarr_readout_properties.sv
// pin-level assertions of the sar serial readout block
`timescale 1ns/10ps
`default_nettype none
`include "sarr_map.svh"
module sarr_readout_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // host pins
  input wire logic frame_sel_n,
  input wire logic serial_clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  // front end and stream
  input wire logic analog_powered,
  input wire logic track_mode,
  input wire logic powerup_done,
  input wire logic [`SARR_RESULT_BITS-1:0] sar_trial,
  input wire logic result_valid,
  input wire logic result_ready,
  input wire sarr_pkg::sarr_result_s result_data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // cycles spent tracking, saturating so a long wait cannot wrap
  logic [7:0] trk_cnt;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) trk_cnt <= 8'h00;
    else if (!track_mode) trk_cnt <= 8'h00;
    else if (trk_cnt != 8'hff) trk_cnt <= trk_cnt + 8'h01;
  end
  // frame start and a serial clock resting high
  sequence s_frame_start;
    $rose(serial_result_oe);
  endsequence
  sequence s_clk_rest;
    serial_clk [*6];
  endsequence
  a_power_on_fall: assert property ($fell(frame_sel_n) |-> ##[2:4] (track_mode && analog_powered))
    else $error("no tracking after select fall");
  a_powerup_time: assert property ($rose(powerup_done) |-> track_mode && trk_cnt >= 8'h64)
    else $error("power-up reported too early");
  a_start_zero: assert property (s_frame_start |-> !serial_result_out && !track_mode && analog_powered)
    else $error("frame start without hold or leading zero");
  a_sar_first: assert property (s_frame_start |-> sar_trial == 12'h800)
    else $error("first trial code wrong");
  a_down_quiet: assert property (!analog_powered |-> !serial_result_oe)
    else $error("output driven while powered down");
  a_track_quiet: assert property (track_mode |-> !serial_result_oe)
    else $error("output driven while tracking");
  a_end_release: assert property ($fell(serial_result_oe) |-> !analog_powered || track_mode)
    else $error("output released without power-down");
  a_fall_only: assert property (s_clk_rest ##0 serial_result_oe |-> $stable(serial_result_out))
    else $error("output moved without a clock fall");
  a_stream_hold: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
    else $error("stream head changed while stalled");
endmodule // sarr_readout_properties
`default_nettype wire

// File: sim/sarr_host_model.sv
// host serial port model with the comparator of the converter core
`timescale 1ns/10ps
`default_nettype none
`include "sarr_map.svh"
module sarr_host_model (
  // clock
  input wire logic core_clk,
  // host pins
  output logic frame_sel_n,
  output logic serial_clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  // converter front end
  input wire logic [`SARR_RESULT_BITS-1:0] sar_trial,
  input wire logic [`SARR_RESULT_BITS-1:0] vin,
  output logic comp_high
);
  logic last = 1'b0;
  logic line;
  // a released line toggles, so a missing drive never reads as a lucky zero
  assign line = serial_result_oe ? serial_result_out : ~last;
  assign comp_high = (vin >= sar_trial);
  always @(posedge core_clk) last <= line;
  initial begin
    frame_sel_n = 1'b1;
    serial_clk = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one frame: tl cycles powered up, nclk clocks of half cycles per phase
  task automatic frame(input int tl, input int half, input int nclk, output logic [15:0] w);
    w = 16'hffff;
    frame_sel_n = 1'b0;
    tick(tl);
    frame_sel_n = 1'b1;
    tick(half);
    w[15] = line;
    for (int i = 1; i <= nclk; i++) begin
      serial_clk = 1'b0;
      tick(half);
      serial_clk = 1'b1;
      if (i < 16) w[15-i] = line;
      tick(half);
    end
  endtask
  // clock bursts with no frame around them
  task automatic wiggle(input int n);
    repeat (n) begin
      serial_clk = 1'b0;
      tick(6);
      serial_clk = 1'b1;
      tick(6);
    end
  endtask
endmodule // sarr_host_model
`default_nettype wire

// File: sim/test_sarr_readout.sv
// self-checking bench of the sar serial readout block
`timescale 1ns/10ps
`default_nettype none
module test_sarr_readout;
  logic core_clk;
  logic resetn;
  logic result_ready;
  logic [11:0] vin;
  wire logic frame_sel_n, serial_clk, serial_result_out, serial_result_oe, analog_powered;
  wire logic track_mode, powerup_done, comp_high, result_valid, result_room;
  wire logic [11:0] sar_trial;
  wire sarr_pkg::sarr_result_s result_data;
  int error_cnt = 0;
  int checks = 0;
  logic [15:0] w;
  always #5 core_clk = ~core_clk;
  // small fifo so a few frames reach the full case
  sarr_readout #(.FIFO_DEPTH(4)) u_sarr_readout (.core_clk(core_clk), .resetn(resetn),
    .frame_sel_n(frame_sel_n), .serial_clk(serial_clk), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .analog_powered(analog_powered), .track_mode(track_mode),
    .powerup_done(powerup_done), .sar_trial(sar_trial), .comp_high(comp_high),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data),
    .result_room(result_room));
  sarr_host_model u_sarr_host_model (.core_clk(core_clk), .frame_sel_n(frame_sel_n),
    .serial_clk(serial_clk), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .sar_trial(sar_trial), .vin(vin), .comp_high(comp_high));
  task automatic end_sim();
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_word(n, {15'h0000, e}, {15'h0000, g});
  endtask
  // bounded wait for power-down, then spacing before the next frame
  task automatic wait_down();
    for (int t = 0; t < 20 && analog_powered !== 1'b0; t++) u_sarr_host_model.tick(1);
    chk_bit("powered", 1'b0, analog_powered);
    chk_bit("oe", 1'b0, serial_result_oe);
    if (analog_powered !== 1'b0) end_sim();
    u_sarr_host_model.tick(700);
  endtask
  // serial clock bursts while powered down change nothing
  task automatic t_idle();
    u_sarr_host_model.wiggle(20);
    chk_bit("idle_oe", 1'b0, serial_result_oe);
    chk_bit("idle_pwr", 1'b0, analog_powered);
    chk_bit("idle_valid", 1'b0, result_valid);
  endtask
  // edge codes at two clock rates fill the fifo; the fifth result is dropped
  task automatic t_fill();
    logic [11:0] c [5] = '{12'h000, 12'hfff, 12'ha5c, 12'h001, 12'h7ff};
    for (int k = 0; k < 5; k++) begin
      vin = c[k];
      u_sarr_host_model.frame(110, (k == 2) ? 20 : 6, 16, w);
      chk_word("word", {4'h0, c[k]}, w);
      wait_down();
    end
    chk_bit("room", 1'b0, result_room);
    // ready stays up across the drain so no edge sees it drop and rise
    result_ready = 1'b1;
    for (int k = 0; k < 4; k++) begin
      chk_bit("valid", 1'b1, result_valid);
      chk_word("code", {4'h0, c[k]}, {4'h0, result_data.code});
      u_sarr_host_model.tick(1);
    end
    result_ready = 1'b0;
    chk_bit("empty", 1'b0, result_valid);
    chk_bit("room_back", 1'b1, result_room);
  endtask
  // a frame cut short after eight clocks is aborted by the next select fall
  task automatic t_abort();
    vin = 12'h3c6;
    u_sarr_host_model.frame(110, 6, 8, w);
    chk_bit("oe_mid", 1'b1, serial_result_oe);
    u_sarr_host_model.tick(800);
    u_sarr_host_model.frame(110, 6, 16, w);
    chk_bit("pwr_done", 1'b1, powerup_done);
    chk_word("word_abort", {4'h0, vin}, w);
    wait_down();
    chk_bit("one_result", 1'b1, result_valid);
    result_ready = 1'b1;
    u_sarr_host_model.tick(1);
    result_ready = 1'b0;
    chk_bit("no_second", 1'b0, result_valid);
  endtask
  // select raised before power-up ends still converts, power-up never reported
  task automatic t_early();
    vin = 12'h5a5;
    u_sarr_host_model.frame(40, 6, 16, w);
    chk_word("word_early", {4'h0, vin}, w);
    chk_bit("pwr_early", 1'b0, powerup_done);
    wait_down();
    chk_bit("valid_early", 1'b1, result_valid);
    chk_word("code_early", {4'h0, vin}, {4'h0, result_data.code});
  endtask
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    result_ready = 1'b0;
    vin = 12'h000;
    u_sarr_host_model.tick(5);
    resetn = 1'b1;
    u_sarr_host_model.tick(3);
    t_idle();
    t_fill();
    t_abort();
    t_early();
    end_sim();
  end
endmodule // test_sarr_readout
bind sarr_readout sarr_readout_properties u_sarr_readout_properties (.core_clk(core_clk), .resetn(resetn),
  .frame_sel_n(frame_sel_n), .serial_clk(serial_clk), .serial_result_out(serial_result_out),
  .serial_result_oe(serial_result_oe), .analog_powered(analog_powered), .track_mode(track_mode),
  .powerup_done(powerup_done), .sar_trial(sar_trial), .result_valid(result_valid),
  .result_ready(result_ready), .result_data(result_data));
`default_nettype wire
